//--- bench/dma_channel_event_irq_ctrl_bench.sv
// self-checking bench for the channel event and interrupt control
`timescale 1ns/100ps
`default_nettype none
module dma_channel_event_irq_ctrl_bench
  import dma_event_pkg::*;
;
  logic         sys_clk;
  logic         rst;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [255:0] irq_lines;
  logic [7:0]   evt;
  logic         cell_start;
  logic         xfer_abort;
  logic         channel_on;
  logic         channel_irq;
  logic [31:0]  rd;
  logic         err;
  int           errors;
  int           comparisons;

  dma_channel_event_irq_ctrl dma_channel_event_irq_ctrl_inst (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_lines(irq_lines),
    .src_done_evt(evt[7]), .src_half_evt(evt[6]), .dst_done_evt(evt[5]),
    .dst_half_evt(evt[4]), .block_done_evt(evt[3]),
    .cell_done_evt(evt[2]), .addr_error_evt(evt[0]),
    .pattern_match_evt(evt[1]), .cell_start(cell_start),
    .xfer_abort(xfer_abort), .channel_on(channel_on),
    .channel_irq(channel_irq));

  engine_model engine_model_inst (
    .sys_clk(sys_clk), .irq_lines(irq_lines), .evt(evt),
    .cell_start(cell_start), .xfer_abort(xfer_abort));

  // 100 MHz clock
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; an idle cycle after release avoids double drives
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    chk({31'h0, channel_on}, 32'h0000_0000);
    rchk(EVENT_CTL_OFS, 32'h00ff_ff00);
    rchk(INT_CTL_OFS, 32'h0000_0000);
    apb(1'b0, 8'h3c, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    wr(CTRL_OFS, 32'h0000_0080);
    wr(EVENT_CTL_OFS, 32'hffc3_2a1f);
    rchk(EVENT_CTL_OFS, 32'h00c3_2a18);
  endtask

  // start numbers at both ends of the range, then the enable cleared
  task automatic t_start();
    logic [7:0] nums [3] = '{8'h00, 8'h2a, 8'hff};
    int s;
    foreach (nums[k]) begin
      wr(EVENT_CTL_OFS, {16'h00c3, nums[k], 8'h10});
      s = engine_model_inst.starts;
      engine_model_inst.pulse_irq(nums[k]);
      idle(3);
      chk(32'(engine_model_inst.starts - s), 32'h0000_0001);
    end
    wr(EVENT_CTL_OFS, 32'h00c3_ff00);
    engine_model_inst.pulse_irq(255);
    idle(3);
    chk(32'(engine_model_inst.starts - s), 32'h0000_0001);
  endtask

  task automatic t_abort(input logic en);
    int s;
    wr(CTRL_OFS, 32'h0000_0080);
    wr(INT_CTL_OFS, 32'h0000_0000);
    wr(EVENT_CTL_OFS, {24'h00c3_00, 4'h0, en, 3'h0});
    s = engine_model_inst.aborts;
    engine_model_inst.pulse_irq(8'hc3);
    idle(3);
    chk(32'(engine_model_inst.aborts - s), {31'h0, en});
    rchk(INT_CTL_OFS, {30'h0, en, 1'b0});
  endtask

  // write-one strobes fire once and read back zero
  task automatic t_strobes();
    int s;
    int a;
    wr(CTRL_OFS, 32'h0000_0080);
    s = engine_model_inst.starts;
    a = engine_model_inst.aborts;
    wr(EVENT_CTL_OFS, 32'h0000_0080);
    rchk(EVENT_CTL_OFS, 32'h0000_0000);
    chk(32'(engine_model_inst.starts - s), 32'h0000_0001);
    rchk(CTRL_OFS, 32'h0000_8080);
    wr(EVENT_CTL_OFS, 32'h0000_0040);
    rchk(EVENT_CTL_OFS, 32'h0000_0000);
    chk(32'(engine_model_inst.aborts - a), 32'h0000_0001);
    rchk(CTRL_OFS, 32'h0000_0080);
  endtask

  task automatic t_flags();
    int fl [7] = '{7, 6, 5, 4, 3, 2, 0};
    wr(INT_CTL_OFS, 32'h0000_0004);
    chk({31'h0, channel_irq}, 32'h0000_0000);
    wr(INT_CTL_OFS, 32'h0004_0004);
    chk({31'h0, channel_irq}, 32'h0000_0001);
    wr(INT_CTL_OFS, 32'h00ff_0000);
    chk({31'h0, channel_irq}, 32'h0000_0000);
    foreach (fl[k]) begin
      engine_model_inst.pulse_evt(fl[k]);
      idle(2);
      chk({31'h0, channel_irq}, 32'h0000_0001);
      rchk(INT_CTL_OFS, 32'h00ff_0000 | (32'h1 << fl[k]));
      wr(INT_CTL_OFS, 32'h00ff_0000);
    end
    wr(INT_CTL_OFS, 32'h0000_0000);
    rchk(INT_CTL_OFS, 32'h0000_0000);
  endtask

  task automatic t_pattern();
    int a;
    wr(CTRL_OFS, 32'h0000_0080);
    wr(EVENT_CTL_OFS, 32'h0000_0020);
    a = engine_model_inst.aborts;
    engine_model_inst.pulse_evt(1);
    idle(3);
    chk({31'h0, channel_on}, 32'h0000_0000);
    chk(32'(engine_model_inst.aborts - a), 32'h0000_0001);
    rchk(INT_CTL_OFS, 32'h0000_0008);
    wr(CTRL_OFS, 32'h0000_0080);
    wr(EVENT_CTL_OFS, 32'h0000_0000);
    engine_model_inst.pulse_evt(1);
    idle(3);
    chk({31'h0, channel_on}, 32'h0000_0001);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // a hang ends the run as a failure; tests need under 2000 cycles
  initial begin
    #100000;
    errors++;
    wrap_up();
  end

  initial begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    idle(5);
    rst <= 1'b0;
    idle(1);
    t_reset();
    t_start();
    t_abort(1'b1);
    t_abort(1'b0);
    t_strobes();
    t_flags();
    t_pattern();
    wrap_up();
  end
endmodule
`default_nettype wire

//--- bench/engine_model.sv
// far-side model: request sources and transfer engine
`timescale 1ns/100ps
`default_nettype none
module engine_model (
  // clock
  input  wire logic         sys_clk,
  // request lines and engine events, idle low
  output logic      [255:0] irq_lines,
  output logic      [7:0]   evt,
  // engine commands
  input  wire logic         cell_start,
  input  wire logic         xfer_abort
);
  int starts;
  int aborts;

  // lines start idle so nothing fires out of reset
  initial begin
    irq_lines = '0;
    evt = '0;
    starts = 0;
    aborts = 0;
  end

  // commands are one-cycle pulses, so one count per high edge
  always @(posedge sys_clk) begin
    if (cell_start === 1'b1) starts++;
    if (xfer_abort === 1'b1) aborts++;
  end

  // one-cycle request pulse on line n
  task automatic pulse_irq(input int n);
    @(posedge sys_clk) irq_lines[n] <= 1'b1;
    @(posedge sys_clk) irq_lines[n] <= 1'b0;
  endtask

  // one-cycle engine event pulse, index is the flag position except 1, which is the pattern match
  task automatic pulse_evt(input int i);
    @(posedge sys_clk) evt[i] <= 1'b1;
    @(posedge sys_clk) evt[i] <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- src/dma_channel_event_irq_ctrl.sv
// channel event and interrupt control with apb register access
`timescale 1ns/100ps
`default_nettype none
module dma_channel_event_irq_ctrl
  import dma_event_pkg::*;
#(
  parameter int IRQ_COUNT = 256
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt request lines, pulses from on-chip logic
  input  wire logic [255:0] irq_lines,
  // transfer engine events, one-cycle pulses
  input  wire logic        src_done_evt,
  input  wire logic        src_half_evt,
  input  wire logic        dst_done_evt,
  input  wire logic        dst_half_evt,
  input  wire logic        block_done_evt,
  input  wire logic        cell_done_evt,
  input  wire logic        addr_error_evt,
  input  wire logic        pattern_match_evt,
  // transfer engine commands
  output logic             cell_start,
  output logic             xfer_abort,
  output logic             channel_on,
  // channel interrupt
  output logic             channel_irq
);

  // the request bus is a fixed 256 lines wide, so no other count is served
  if (IRQ_COUNT != 256) begin : g_bad_count
    $error("IRQ_COUNT must be 256");
  end

  // registers
  logic       channel_on_reg;
  logic       busy_reg;
  logic [7:0] abort_request_number_reg;
  logic [7:0] start_request_number_reg;
  logic       pattern_abort_enable_reg;
  logic       start_request_enable_reg;
  logic       abort_request_enable_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic       cell_start_reg;
  logic       xfer_abort_reg;
  logic       channel_irq_reg;
  logic [31:0] prdata_reg;
  logic       pready_reg;
  logic       pslverr_reg;

  // apb decode; one wait state, answer in the second access cycle
  wire access     = psel & penable & ~pready_reg;
  wire wr_access  = access & pwrite;
  wire rd_access  = access & ~pwrite;
  wire hit_ctrl   = (paddr == CTRL_OFS);
  wire hit_event  = (paddr == EVENT_CTL_OFS);
  wire hit_int    = (paddr == INT_CTL_OFS);
  wire mapped     = hit_ctrl | hit_event | hit_int;
  wire wr_ctrl    = wr_access & hit_ctrl;
  wire wr_event   = wr_access & hit_event;
  wire wr_int     = wr_access & hit_int;

  // strobes only on a written one
  wire force_strobe = wr_event & pwdata[FORCE_BIT]; // R3 R5
  wire sw_abort     = wr_event & pwdata[SW_ABORT_BIT]; // R4 R5

  // request matchers
  wire start_hit;
  wire abort_hit;
  req_match u_start_match (
    .irq_lines  (irq_lines),
    .irq_number (start_request_number_reg),
    .match_en   (start_request_enable_reg),
    .hit        (start_hit)
  ); // R2 R7
  req_match u_abort_match (
    .irq_lines  (irq_lines),
    .irq_number (abort_request_number_reg),
    .match_en   (abort_request_enable_reg),
    .hit        (abort_hit)
  ); // R1 R8

  // pattern match counts only when enabled
  wire pat_abort = pattern_abort_enable_reg & pattern_match_evt; // R6
  // abort requests only count while the channel is on
  wire req_abort = abort_hit & channel_on_reg; // R1 R8
  wire any_abort = req_abort | sw_abort | pat_abort;
  // start needs the channel on and no abort in the same cycle
  wire any_start = (start_hit | force_strobe) & channel_on_reg
                   & ~any_abort; // R3 R7

  // event vector in flag order
  wire [7:0] evt_vec = {src_done_evt, src_half_evt, // R10
                        dst_done_evt, dst_half_evt,
                        block_done_evt | pat_abort, // R13
                        cell_done_evt, req_abort, // R15 R14
                        addr_error_evt};

  // flag update: hardware set wins over software clear
  wire [7:0] flag_wr = wr_int ? pwdata[FLAG_LSB +: 8] : flag_reg;
  assign flag_next = flag_wr | evt_vec; // R13 R14 R15

  // read mux; unimplemented bits read zero
  wire [31:0] ctrl_rd  = {16'h0000, busy_reg, 7'h00, channel_on_reg, 7'h00};
  wire [31:0] event_rd = {8'h00, abort_request_number_reg,
                          start_request_number_reg, 2'b00,
                          pattern_abort_enable_reg,
                          start_request_enable_reg,
                          abort_request_enable_reg, 3'b000}; // R5 R9
  wire [31:0] int_rd   = {8'h00, irq_en_reg, 8'h00, flag_reg}; // R10 R11
  wire [31:0] rd_mux   = hit_ctrl  ? ctrl_rd :
                         hit_event ? event_rd :
                         hit_int   ? int_rd : 32'h0000_0000;

  // apb answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access & ~mapped;
      prdata_reg  <= rd_access ? rd_mux : 32'h0000_0000;
    end
  end

  // channel control; pattern abort clears the enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel_on_reg <= 1'b0;
    end else if (pat_abort) begin
      channel_on_reg <= 1'b0; // R6
    end else if (wr_ctrl) begin
      channel_on_reg <= pwdata[CH_ON_BIT];
    end
  end

  // busy: set by a start, cleared by abort, block end or disable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (any_abort | block_done_evt | ~channel_on_reg) begin
      busy_reg <= 1'b0;
    end else if (any_start) begin
      busy_reg <= 1'b1;
    end
  end

  // event control fields
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      abort_request_number_reg <= ABORT_NUM_RST;
      start_request_number_reg <= START_NUM_RST;
      pattern_abort_enable_reg <= 1'b0;
      start_request_enable_reg <= 1'b0;
      abort_request_enable_reg <= 1'b0;
    end else if (wr_event) begin
      abort_request_number_reg <= pwdata[ABORT_NUM_LSB +: 8]; // R1
      start_request_number_reg <= pwdata[START_NUM_LSB +: 8]; // R2
      pattern_abort_enable_reg <= pwdata[PAT_EN_BIT]; // R6
      start_request_enable_reg <= pwdata[START_EN_BIT]; // R7
      abort_request_enable_reg <= pwdata[ABORT_EN_BIT]; // R8
    end
  end

  // interrupt enables and flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_en_reg <= IRQ_EN_RST; // R12
      flag_reg   <= 8'h00;
    end else begin
      if (wr_int) begin
        irq_en_reg <= pwdata[IRQ_EN_LSB +: 8]; // R12
      end
      flag_reg <= flag_next;
    end
  end

  // engine commands and interrupt, all registered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cell_start_reg  <= 1'b0;
      xfer_abort_reg  <= 1'b0;
      channel_irq_reg <= 1'b0;
    end else begin
      cell_start_reg  <= any_start; // R3 R7
      xfer_abort_reg  <= any_abort; // R1 R4 R6
      channel_irq_reg <= |(flag_next & irq_en_reg); // R16
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign cell_start  = cell_start_reg;
  assign xfer_abort  = xfer_abort_reg;
  assign channel_on  = channel_on_reg;
  assign channel_irq = channel_irq_reg;

  // checks
  property p_sw_abort;
    @(posedge sys_clk) disable iff (rst)
      sw_abort |=> xfer_abort;
  endproperty
  a_sw_abort: assert property (p_sw_abort) // R4
    else $error("sw abort lost");

  property p_req_abort_flag;
    @(posedge sys_clk) disable iff (rst)
      req_abort |=> flag_reg[F_ABORT] && xfer_abort;
  endproperty
  a_req_abort_flag: assert property (p_req_abort_flag) // R1
    else $error("abort flag");

  property p_abort_gate;
    @(posedge sys_clk) disable iff (rst)
      (!abort_request_enable_reg && !sw_abort && !pat_abort) |=> !xfer_abort;
  endproperty
  a_abort_gate: assert property (p_abort_gate) // R8
    else $error("abort ungated");

  property p_start_gate;
    @(posedge sys_clk) disable iff (rst)
      (!start_request_enable_reg && !force_strobe) |=> !cell_start;
  endproperty
  a_start_gate: assert property (p_start_gate) // R7
    else $error("start ungated");

  property p_force;
    @(posedge sys_clk) disable iff (rst)
      (force_strobe && channel_on_reg && !any_abort) |=> cell_start;
  endproperty
  a_force: assert property (p_force) // R3
    else $error("force lost");

  property p_strobe_read;
    @(posedge sys_clk) disable iff (rst)
      (rd_access && hit_event) |=> prdata[7:6] == 2'b00 && prdata[2:0] == 3'b000
        && prdata[31:24] == 8'h00;
  endproperty
  a_strobe_read: assert property (p_strobe_read) // R5
    else $error("strobe reads one");

  property p_pattern;
    @(posedge sys_clk) disable iff (rst)
      pat_abort |=> !channel_on_reg && flag_reg[F_BLOCK];
  endproperty
  a_pattern: assert property (p_pattern) // R6
    else $error("pattern abort");

  property p_cell_flag;
    @(posedge sys_clk) disable iff (rst)
      cell_done_evt |=> flag_reg[F_CELL];
  endproperty
  a_cell_flag: assert property (p_cell_flag) // R15
    else $error("cell flag");

  property p_irq;
    @(posedge sys_clk) disable iff (rst)
      1'b1 |=> channel_irq == |($past(flag_next) & $past(irq_en_reg));
  endproperty
  a_irq: assert property (p_irq) // R16
    else $error("irq output");

  property p_int_read;
    @(posedge sys_clk) disable iff (rst)
      (rd_access && hit_int) |=> prdata[31:24] == 8'h00
        && prdata[15:8] == 8'h00;
  endproperty
  a_int_read: assert property (p_int_read) // R11
    else $error("int reserved");

  // a request start reaches the engine one cycle later, never with an abort
  sequence s_start_request;
    start_hit && channel_on_reg && !any_abort;
  endsequence

  sequence s_start_pulse;
    cell_start && !xfer_abort;
  endsequence

  property p_req_start;
    @(posedge sys_clk) disable iff (rst)
      s_start_request |=> s_start_pulse;
  endproperty
  a_req_start: assert property (p_req_start) // R2 R7
    else $error("request start lost");

  // a written abort wins over any start in the same cycle
  sequence s_sw_abort_write;
    wr_event && pwdata[SW_ABORT_BIT];
  endsequence

  property p_abort_beats_start;
    @(posedge sys_clk) disable iff (rst)
      s_sw_abort_write |=> xfer_abort && !cell_start;
  endproperty
  a_abort_beats_start: assert property (p_abort_beats_start) // R4
    else $error("start escaped an abort");

  // enables leave reset cleared, then follow the written value
  property p_en_reset;
    @(posedge sys_clk)
      rst |=> irq_en_reg == IRQ_EN_RST;
  endproperty
  a_en_reset: assert property (p_en_reset) // R12
    else $error("enable reset value");

  property p_en_write;
    @(posedge sys_clk) disable iff (rst)
      wr_int |=> irq_en_reg == $past(pwdata[IRQ_EN_LSB +: 8]);
  endproperty
  a_en_write: assert property (p_en_write) // R12
    else $error("enable write lost");

  // no flag may drop without a software write, so the interrupt holds
  property p_flag_hold;
    @(posedge sys_clk) disable iff (rst)
      !wr_int |=> (flag_reg & $past(flag_reg)) == $past(flag_reg);
  endproperty
  a_flag_hold: assert property (p_flag_hold) // R16
    else $error("flag dropped by itself");

  // both ends of the flag group land in their own positions
  property p_src_done_flag;
    @(posedge sys_clk) disable iff (rst)
      src_done_evt |=> flag_reg[F_SRC_DONE];
  endproperty
  a_src_done_flag: assert property (p_src_done_flag) // R10
    else $error("source done flag");

  property p_addr_err_flag;
    @(posedge sys_clk) disable iff (rst)
      addr_error_evt |=> flag_reg[F_ADDR_ERR];
  endproperty
  a_addr_err_flag: assert property (p_addr_err_flag) // R10
    else $error("address error flag");

  property p_block_flag;
    @(posedge sys_clk) disable iff (rst)
      block_done_evt |=> flag_reg[F_BLOCK];
  endproperty
  a_block_flag: assert property (p_block_flag) // R13
    else $error("block done flag");

endmodule
`default_nettype wire

//--- src/dma_event_pkg.sv
// constants shared by the channel event and interrupt control block
//
// Operation
// R1: an abort request number in event control bits 23-16, reset all ones, aborts the transfer and sets the abort flag when enabled and matched;
// the code does both only while the channel is on.
// R2: a start request number in event control bits 15-8, reset all ones, selects any request 0 to 255 as the start trigger.
// R3: writing one to event control bit 7 starts a transfer at once without a request.
// the code starts only while the channel is on and no abort comes in the same cycle.
// R4: writing one to event control bit 6 aborts the channel transfer.
// R5: bits 7 and 6 are write-one strobes that read zero, and writing zero to them does nothing.
// R6: with bit 5 set a pattern match aborts the transfer and clears the channel enable; with it clear matching is off.
// R7: with bit 4 set a request equal to the start number starts one cell transfer; with it clear the request is ignored.
// the code starts only while the channel is on and no abort comes in the same cycle.
// R8: with bit 3 set a request equal to the abort number aborts the transfer; with it clear the request is ignored.
// R9: event control bits 31-24 and 2-0 read zero.
// R10: interrupt control holds eight enables in 23:16 and eight flags in 7:0, both ordered src done, src half, dst done, dst half, block, cell, abort, address error.
// R11: interrupt control bits 31-24 and 15-8 read zero.
// R12: each interrupt enable is read/write and resets to zero.
// R13: the block done flag sets when a block completes or on a pattern match.
// R14: the transfer abort flag sets when a matching abort request aborts the transfer.
// R15: the cell done flag sets each time one cell has moved.
// R16: the interrupt output is high while any flag and its enable are both one, until software clears the flag.
package dma_event_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] EVENT_CTL_OFS = 8'h10;
  localparam logic [7:0] INT_CTL_OFS   = 8'h20;

  // channel control fields
  localparam int CH_ON_BIT   = 7;
  localparam int CH_BUSY_BIT = 15;

  // event control fields
  localparam int ABORT_NUM_LSB  = 16;
  localparam int START_NUM_LSB  = 8;
  localparam int FORCE_BIT      = 7;
  localparam int SW_ABORT_BIT   = 6;
  localparam int PAT_EN_BIT     = 5;
  localparam int START_EN_BIT   = 4;
  localparam int ABORT_EN_BIT   = 3;

  // interrupt control fields
  localparam int IRQ_EN_LSB = 16;
  localparam int FLAG_LSB   = 0;

  // flag positions inside the 8-bit groups
  localparam int F_SRC_DONE = 7;
  localparam int F_SRC_HALF = 6;
  localparam int F_DST_DONE = 5;
  localparam int F_DST_HALF = 4;
  localparam int F_BLOCK    = 3;
  localparam int F_CELL     = 2;
  localparam int F_ABORT    = 1;
  localparam int F_ADDR_ERR = 0;

  // values after reset
  localparam logic [7:0] ABORT_NUM_RST = 8'hFF;
  localparam logic [7:0] START_NUM_RST = 8'hFF;
  localparam logic [7:0] IRQ_EN_RST    = 8'h00;

endpackage

//--- src/req_match.sv
// one request-number comparator with its enable
`timescale 1ns/100ps
`default_nettype none
module req_match
  import dma_event_pkg::*;
(
  // request line side
  input  wire logic [255:0] irq_lines,
  input  wire logic [7:0]   irq_number,
  input  wire logic         match_en,
  // result
  output logic              hit
);
  // selected line gated by its enable
  assign hit = match_en & irq_lines[irq_number];
endmodule
`default_nettype wire
